// ### design/dcff_buffer.sv
`timescale 1ns/1ns
`default_nettype none
module dcff_buffer #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8,
    parameter int PW    = $clog2(DEPTH) + 1
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [WIDTH-1:0] out_data,
    output var  logic [PW-1:0]    wr_ptr,
    output var  logic [PW-1:0]    rd_ptr
);
    localparam int AW = PW - 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic             push;
    logic             pop;

    always_comb
    begin
        // full when indices match but wrap bits differ
        in_ready    = !((wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]));
        out_valid   = (wr_ptr != rd_ptr);
        push        = in_valid && in_ready;
        pop         = out_ready && out_valid;
        next_wr_ptr = wr_ptr + PW'(push);
        next_rd_ptr = rd_ptr + PW'(pop);
        out_data    = mem[rd_ptr[AW-1:0]];
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // storage carries no reset so it maps onto ram
    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem[wr_ptr[AW-1:0]] <= in_data;
    end

endmodule : dcff_buffer
`default_nettype wire

// ### design/dcff_flags.sv
// Contract
// - port b decode, tristate, queue/mail choice
// - flags pass two stages of port clock
// - each port's flags in its domain
// - fall-through ready: word in output register
// - standard empty high: word waiting in memory
// - read pointer advances per output load
// - fall-through load on third read edge
// - standard empty rises on second read edge
// - same-instant write counts from next edge
// - full/ready low blocks writes
// - write pointer advances per write
// - full/ready rises on second write edge
// - same-instant read counts from next edge
// - a-to-b thresholds from depth and offsets
// - b-to-a same thresholds, mirrored ports
// - output register word not counted
// - shifted word frees its location immediately
// - flag meaning follows the timing mode
// - comparator classes feed flag machines
// - offsets map to their flags
// - port a decode mirrors port b
`timescale 1ns/1ns
`default_nettype none
module dcff_flags
    import dcff_pkg::*;
#(
    parameter int DEPTH = dcff_pkg::DEF_DEPTH,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rstn,
    input  wire logic                        fall_through_mode,
    input  wire logic                        port_a_clock,
    input  wire logic                        port_a_select_n,
    input  wire logic                        port_a_direction,
    input  wire logic                        port_a_enable,
    input  wire logic                        port_a_mail_select,
    input  wire logic [dcff_pkg::DATA_W-1:0] port_a_data_in,
    output var  logic [dcff_pkg::DATA_W-1:0] port_a_data_out,
    output var  logic                        port_a_data_oe_n,
    input  wire logic                        port_b_clock,
    input  wire logic                        port_b_select_n,
    input  wire logic                        port_b_direction,
    input  wire logic                        port_b_enable,
    input  wire logic                        port_b_mail_select,
    input  wire logic [dcff_pkg::DATA_W-1:0] port_b_data_in,
    output var  logic [dcff_pkg::DATA_W-1:0] port_b_data_out,
    output var  logic                        port_b_data_oe_n,
    input  wire logic [AW-1:0]               a_to_b_empty_offset,
    input  wire logic [AW-1:0]               a_to_b_full_offset,
    input  wire logic [AW-1:0]               b_to_a_empty_offset,
    input  wire logic [AW-1:0]               b_to_a_full_offset,
    output var  logic                        port_a_empty_or_ready,
    output var  logic                        port_a_almost_empty_n,
    output var  logic                        port_a_almost_full_n,
    output var  logic                        port_a_full_or_ready,
    output var  logic                        port_b_empty_or_ready,
    output var  logic                        port_b_almost_empty_n,
    output var  logic                        port_b_almost_full_n,
    output var  logic                        port_b_full_or_ready,
    output var  logic                        mail_one_flag_n,
    output var  logic                        mail_two_flag_n
);
    import dcff_pkg::*;

    localparam int            PW      = AW + 1;
    localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);

    // comparator classes: nothing, one, two, or more than two above the boundary
    function automatic dcff_fill_e fill_class(input logic [PW-1:0] n);
        if (n == '0)
            return LVL_EMPTY;
        if (n == PW'(1))
            return LVL_ONE;
        if (n == PW'(2))
            return LVL_TWO;
        return LVL_MORE;
    endfunction : fill_class

    logic [SYNC_STAGES-1:0] ft_sync;
    logic                   ft;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            ft_sync <= '0;
        else
            ft_sync <= {ft_sync[SYNC_STAGES-2:0], fall_through_mode};
    end

    assign ft = ft_sync[SYNC_STAGES-1];

    genvar p;
    genvar q;

    for (p = 0; p < 2; p++)
    begin : gen_port
        logic [PIN_W-1:0]  pins;
        logic [PIN_W-1:0]  s1;
        logic [PIN_W-1:0]  s2;
        logic [PIN_W-1:0]  s3;
        logic              clk_lvl;
        logic              next_clk_lvl;
        logic              clk_edge;
        logic              writing;
        dcff_op_e          op;
        logic              op_qwr;
        logic              op_qrd;
        logic              op_mwr;
        logic              op_mrd;
        logic [DATA_W-1:0] data_out;
        logic [DATA_W-1:0] next_data_out;
        logic              oe_n;
        logic              next_oe_n;

        assign pins = (p == PORT_A)
            ? {port_a_clock, port_a_select_n, port_a_direction, port_a_enable, port_a_mail_select, port_a_data_in}
            : {port_b_clock, port_b_select_n, port_b_direction, port_b_enable, port_b_mail_select, port_b_data_in};

        always_comb
        begin
            // a port clock edge counts once the second and third stages agree
            next_clk_lvl = (s2[PIN_CLOCK] == s3[PIN_CLOCK]) ? s3[PIN_CLOCK] : clk_lvl;
            clk_edge     = next_clk_lvl && !clk_lvl;
            // controls are taken from the third stage, the same sample that completes the clock edge
            writing = (p == PORT_A) ? s3[PIN_DIR] : !s3[PIN_DIR];
            op      = dcff_decode(s3[PIN_SEL_N], writing, s3[PIN_ENABLE], s3[PIN_MAIL]);
            op_qwr  = clk_edge && (op == OP_QUEUE_WR);
            op_qrd  = clk_edge && (op == OP_QUEUE_RD);
            op_mwr  = clk_edge && (op == OP_MAIL_WR);
            op_mrd  = clk_edge && (op == OP_MAIL_RD);
            // pin floats unless selected and reading
            next_oe_n     = s3[PIN_SEL_N] || writing;
            next_data_out = s3[PIN_MAIL] ? gen_q[1-p].mail : gen_q[1-p].out_word;
        end

        always_ff @(posedge clk_sys or negedge rstn)
        begin
            if (!rstn)
            begin
                s1       <= '0;
                s2       <= '0;
                s3       <= '0;
                clk_lvl  <= 1'b0;
                data_out <= '0;
                oe_n     <= RST_DATA_OE_N;
            end
            else
            begin
                s1       <= pins;
                s2       <= s1;
                s3       <= s2;
                clk_lvl  <= next_clk_lvl;
                data_out <= next_data_out;
                oe_n     <= next_oe_n;
            end
        end
    end

    for (q = 0; q < 2; q++)
    begin : gen_q
        // queue q is written by port q and read by the opposite port
        logic [PW-1:0]     wr_ptr;
        logic [PW-1:0]     rd_ptr;
        logic [PW-1:0]     w1;
        logic [PW-1:0]     w2;
        logic [PW-1:0]     r1;
        logic [PW-1:0]     next_w1;
        logic [PW-1:0]     next_w2;
        logic [PW-1:0]     next_r1;
        logic [PW-1:0]     rd_words;
        logic [PW-1:0]     wr_words;
        logic [AW-1:0]     x_off;
        logic [AW-1:0]     y_off;
        logic [DATA_W-1:0] mem_word;
        logic [DATA_W-1:0] out_word;
        logic [DATA_W-1:0] next_out_word;
        logic [DATA_W-1:0] mail;
        logic [DATA_W-1:0] next_mail;
        logic              er;
        logic              ae_n;
        logic              af_n;
        logic              fr;
        logic              mb_n;
        logic              next_er;
        logic              next_ae_n;
        logic              next_af_n;
        logic              next_fr;
        logic              next_mb_n;
        logic              buf_in_ready;
        logic              buf_out_valid;
        logic              wr_go;
        logic              load;
        logic              rd_req;
        logic              rd_edge;
        logic              wr_edge;

        assign x_off = (q == 0) ? a_to_b_empty_offset : b_to_a_empty_offset;
        assign y_off = (q == 0) ? a_to_b_full_offset : b_to_a_full_offset;

        always_comb
        begin
            wr_edge = gen_port[q].clk_edge;
            rd_edge = gen_port[1-q].clk_edge;
            rd_req  = gen_port[1-q].op_qrd;
            // writes while not ready are dropped
            wr_go = gen_port[q].op_qwr && fr && buf_in_ready;
            if (ft)
                load = rd_edge && buf_out_valid && (w2 != rd_ptr) && (!er || rd_req);
            else
                load = rd_req && er && buf_out_valid;
            // the loaded word has left memory and no longer counts
            rd_words = w1 - (rd_ptr + PW'(load));
            wr_words = (wr_ptr + PW'(wr_go)) - r1;
            next_w1       = w1;
            next_w2       = w2;
            next_r1       = r1;
            next_er       = er;
            next_ae_n     = ae_n;
            next_af_n     = af_n;
            next_fr       = fr;
            next_out_word = load ? mem_word : out_word;
            if (rd_edge)
            begin
                // a write in the same sample as this edge is seen one edge later
                next_w1   = wr_ptr;
                next_w2   = w1;
                next_ae_n = rd_words > PW'(x_off);
                if (ft)
                    next_er = load ? 1'b1 : (rd_req ? 1'b0 : er);
                else
                    next_er = fill_class(rd_words) != LVL_EMPTY;
            end
            if (wr_edge)
            begin
                next_r1   = rd_ptr;
                next_fr   = fill_class(DEPTH_P - wr_words) != LVL_EMPTY;
                next_af_n = wr_words < (DEPTH_P - PW'(y_off));
            end
            // a mail write is taken only while the mailbox is empty, even with a clearing read in the same sample
            next_mail = mail;
            next_mb_n = mb_n;
            if (gen_port[1-q].op_mrd)
                next_mb_n = 1'b1;
            if (gen_port[q].op_mwr && mb_n)
            begin
                next_mail = gen_port[q].s3[PIN_DATA_LSB +: DATA_W];
                next_mb_n = 1'b0;
            end
        end

        always_ff @(posedge clk_sys or negedge rstn)
        begin
            if (!rstn)
            begin
                w1       <= '0;
                w2       <= '0;
                r1       <= '0;
                er       <= RST_EMPTY_OR_READY;
                ae_n     <= RST_ALMOST_EMPTY_N;
                af_n     <= RST_ALMOST_FULL_N;
                fr       <= RST_FULL_OR_READY;
                mb_n     <= RST_MAIL_FLAG_N;
                out_word <= '0;
                mail     <= '0;
            end
            else
            begin
                w1       <= next_w1;
                w2       <= next_w2;
                r1       <= next_r1;
                er       <= next_er;
                ae_n     <= next_ae_n;
                af_n     <= next_af_n;
                fr       <= next_fr;
                mb_n     <= next_mb_n;
                out_word <= next_out_word;
                mail     <= next_mail;
            end
        end

        // pointers advance inside the buffer on each push and pop
        dcff_buffer #(
            .WIDTH (DATA_W),
            .DEPTH (DEPTH),
            .PW    (PW)
        ) u_queue (
            .clk_sys   (clk_sys),
            .rstn      (rstn),
            .in_valid  (wr_go),
            .in_ready  (buf_in_ready),
            .in_data   (gen_port[q].s3[PIN_DATA_LSB +: DATA_W]),
            .out_valid (buf_out_valid),
            .out_ready (load),
            .out_data  (mem_word),
            .wr_ptr    (wr_ptr),
            .rd_ptr    (rd_ptr)
        );
    end

    // each queue flag register is updated only on its own port's edges; mail flags move on edges of both ports
    assign port_a_full_or_ready  = gen_q[0].fr;
    assign port_a_almost_full_n  = gen_q[0].af_n;
    assign port_b_empty_or_ready = gen_q[0].er;
    assign port_b_almost_empty_n = gen_q[0].ae_n;
    assign port_b_full_or_ready  = gen_q[1].fr;
    assign port_b_almost_full_n  = gen_q[1].af_n;
    assign port_a_empty_or_ready = gen_q[1].er;
    assign port_a_almost_empty_n = gen_q[1].ae_n;
    assign mail_one_flag_n       = gen_q[0].mb_n;
    assign mail_two_flag_n       = gen_q[1].mb_n;
    assign port_a_data_out       = gen_port[PORT_A].data_out;
    assign port_a_data_oe_n      = gen_port[PORT_A].oe_n;
    assign port_b_data_out       = gen_port[PORT_B].data_out;
    assign port_b_data_oe_n      = gen_port[PORT_B].oe_n;

endmodule : dcff_flags
`default_nettype wire

// ### pkg/dcff_pkg.sv
package dcff_pkg;

    localparam int DATA_W      = 36;
    localparam int DEF_DEPTH   = 2048;
    localparam int BUF_DEPTH   = 8;
    localparam int SYNC_STAGES = 3;

    localparam int PORT_A = 0;
    localparam int PORT_B = 1;

    // field positions inside the per-port pin capture vector
    localparam int PIN_DATA_LSB = 0;
    localparam int PIN_MAIL     = 36;
    localparam int PIN_ENABLE   = 37;
    localparam int PIN_DIR      = 38;
    localparam int PIN_SEL_N    = 39;
    localparam int PIN_CLOCK    = 40;
    localparam int PIN_W        = 41;

    localparam logic RST_EMPTY_OR_READY = 1'b0;
    localparam logic RST_ALMOST_EMPTY_N = 1'b0;
    localparam logic RST_ALMOST_FULL_N  = 1'b1;
    localparam logic RST_FULL_OR_READY  = 1'b0;
    localparam logic RST_MAIL_FLAG_N    = 1'b1;
    localparam logic RST_DATA_OE_N      = 1'b1;

    typedef enum logic [3:0] {
        LVL_EMPTY = 4'h1,
        LVL_ONE   = 4'h2,
        LVL_TWO   = 4'h4,
        LVL_MORE  = 4'h8
    } dcff_fill_e;

    typedef enum logic [4:0] {
        OP_NONE     = 5'h01,
        OP_QUEUE_WR = 5'h02,
        OP_QUEUE_RD = 5'h04,
        OP_MAIL_WR  = 5'h08,
        OP_MAIL_RD  = 5'h10
    } dcff_op_e;

    function automatic dcff_op_e dcff_decode(input logic select_n, input logic writing,
                                             input logic enable, input logic mail);
        if (select_n || !enable)
            return OP_NONE;
        if (writing)
            return mail ? OP_MAIL_WR : OP_QUEUE_WR;
        return mail ? OP_MAIL_RD : OP_QUEUE_RD;
    endfunction : dcff_decode

endpackage : dcff_pkg

// ### sim/dcff_flags_properties.sv
`timescale 1ns/1ns
`default_nettype none
module dcff_flags_properties #(
    parameter int DEPTH = 2048,
    parameter int AW    = $clog2(DEPTH)
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic fall_through_mode,
    input wire logic port_a_clock,
    input wire logic port_a_select_n,
    input wire logic port_a_direction,
    input wire logic port_a_data_oe_n,
    input wire logic port_a_empty_or_ready,
    input wire logic port_a_almost_full_n,
    input wire logic port_a_full_or_ready,
    input wire logic port_b_clock,
    input wire logic port_b_select_n,
    input wire logic port_b_direction,
    input wire logic port_b_data_oe_n,
    input wire logic port_b_empty_or_ready,
    input wire logic port_b_almost_empty_n,
    input wire logic port_b_almost_full_n,
    input wire logic port_b_full_or_ready,
    input wire logic mail_one_flag_n,
    input wire logic mail_two_flag_n
);
    // pins pass a three-flop sampler, so quiet windows are eight samples long
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    reset_levels_a: assert property ($rose(rstn) |-> !port_a_full_or_ready && !port_b_full_or_ready
        && !port_b_empty_or_ready && port_a_almost_full_n && mail_one_flag_n) else $error("flags wrong after reset");
    b_bus_released_a: assert property (port_b_select_n[*8] |-> port_b_data_oe_n)
        else $error("port b drives while deselected");
    b_bus_driven_a: assert property ((!port_b_select_n && port_b_direction)[*8] |-> !port_b_data_oe_n)
        else $error("port b silent while reading");
    a_bus_released_a: assert property (port_a_select_n[*8] |-> port_a_data_oe_n)
        else $error("port a drives while deselected");
    a_bus_driven_a: assert property ((!port_a_select_n && !port_a_direction)[*8] |-> !port_a_data_oe_n)
        else $error("port a silent while reading");
    a_flags_hold_a: assert property (!port_a_clock[*8] |-> $stable(port_a_empty_or_ready)
        && $stable(port_a_full_or_ready) && $stable(port_a_almost_full_n)) else $error("port a flag moved");
    b_flags_hold_a: assert property (!port_b_clock[*8] |-> $stable(port_b_empty_or_ready)
        && $stable(port_b_full_or_ready) && $stable(port_b_almost_empty_n) && $stable(port_b_almost_full_n))
        else $error("port b flag moved");
    mail_flags_hold_a: assert property ((!port_a_clock && !port_b_clock)[*8] |-> $stable(mail_one_flag_n)
        && $stable(mail_two_flag_n)) else $error("mail flag moved without an edge");
    full_means_almost_a: assert property ($fell(port_a_full_or_ready) |-> !port_a_almost_full_n)
        else $error("full without almost full");
    fill_needs_data_a: assert property (!fall_through_mode && port_b_almost_empty_n |-> port_b_empty_or_ready)
        else $error("almost empty high while empty");
endmodule : dcff_flags_properties
bind dcff_flags dcff_flags_properties #(.DEPTH(DEPTH), .AW(AW)) u_flags_props (
    .clk_sys, .rstn, .fall_through_mode, .port_a_clock, .port_a_select_n, .port_a_direction,
    .port_a_data_oe_n, .port_a_empty_or_ready, .port_a_almost_full_n, .port_a_full_or_ready,
    .port_b_clock, .port_b_select_n, .port_b_direction, .port_b_data_oe_n, .port_b_empty_or_ready,
    .port_b_almost_empty_n, .port_b_almost_full_n, .port_b_full_or_ready, .mail_one_flag_n, .mail_two_flag_n
);
`default_nettype wire

// ### sim/dcff_port_master.sv
`timescale 1ns/1ns
`default_nettype none
module dcff_port_master #(
    parameter logic WR_LEVEL = 1'b1
) (
    input  wire logic                        clk_sys,
    output var  logic                        port_clock,
    output var  logic                        select_n,
    output var  logic                        direction,
    output var  logic                        enable,
    output var  logic                        mail_select,
    output var  logic [dcff_pkg::DATA_W-1:0] data_in,
    input  wire logic [dcff_pkg::DATA_W-1:0] data_out,
    input  wire logic                        data_oe_n
);
    import dcff_pkg::*;
    initial
    begin
        port_clock  = 1'b0;
        select_n    = 1'b1;
        direction   = ~WR_LEVEL;
        enable      = 1'b0;
        mail_select = 1'b0;
        data_in     = '0;
    end
    // controls settle four samples before the pin edge and hold to the end of the cycle
    task automatic op(input logic sel_n, input logic wr, input logic en, input logic mail,
                      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q, output logic oe_n);
        @(negedge clk_sys);
        select_n    <= sel_n;
        direction   <= wr ? WR_LEVEL : ~WR_LEVEL;
        enable      <= en;
        mail_select <= mail;
        // an undriven bus shows the inverse of its last value
        data_in     <= wr ? d : ~data_in;
        repeat (4) @(negedge clk_sys);
        port_clock <= 1'b1;
        repeat (4) @(negedge clk_sys);
        port_clock <= 1'b0;
        repeat (4) @(negedge clk_sys);
        q    = data_out;
        oe_n = data_oe_n;
    endtask : op
endmodule : dcff_port_master
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import dcff_pkg::*;
    localparam int DEPTH_T = 16;
    localparam int X1      = 2;
    localparam int Y1      = 2;
    localparam int X2      = 3;
    localparam int Y2      = 3;
    localparam int IDLE    = 0;
    localparam int WR      = 1;
    localparam int RD      = 2;
    localparam int LIMIT   = 10000;
    logic              clk_sys, rstn, fall_through_mode, mb1_n, mb2_n, oe;
    logic              a_clk, a_sel_n, a_dir, a_en, a_mail, a_oe_n, a_eor, a_aen, a_afn, a_for;
    logic              b_clk, b_sel_n, b_dir, b_en, b_mail, b_oe_n, b_eor, b_aen, b_afn, b_for;
    logic [DATA_W-1:0] a_din, a_dout, b_din, b_dout, q;
    int                i, cycles, miscompares, tests_run;
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    dcff_flags #(.DEPTH(DEPTH_T)) dut (
        .clk_sys(clk_sys), .rstn(rstn), .fall_through_mode(fall_through_mode),
        .port_a_clock(a_clk), .port_a_select_n(a_sel_n), .port_a_direction(a_dir), .port_a_enable(a_en),
        .port_a_mail_select(a_mail), .port_a_data_in(a_din), .port_a_data_out(a_dout), .port_a_data_oe_n(a_oe_n),
        .port_b_clock(b_clk), .port_b_select_n(b_sel_n), .port_b_direction(b_dir), .port_b_enable(b_en),
        .port_b_mail_select(b_mail), .port_b_data_in(b_din), .port_b_data_out(b_dout), .port_b_data_oe_n(b_oe_n),
        .a_to_b_empty_offset(4'(X1)), .a_to_b_full_offset(4'(Y1)),
        .b_to_a_empty_offset(4'(X2)), .b_to_a_full_offset(4'(Y2)),
        .port_a_empty_or_ready(a_eor), .port_a_almost_empty_n(a_aen), .port_a_almost_full_n(a_afn),
        .port_a_full_or_ready(a_for), .port_b_empty_or_ready(b_eor), .port_b_almost_empty_n(b_aen),
        .port_b_almost_full_n(b_afn), .port_b_full_or_ready(b_for), .mail_one_flag_n(mb1_n), .mail_two_flag_n(mb2_n)
    );
    dcff_port_master #(.WR_LEVEL(1'b1)) pa (
        .clk_sys(clk_sys), .port_clock(a_clk), .select_n(a_sel_n), .direction(a_dir), .enable(a_en),
        .mail_select(a_mail), .data_in(a_din), .data_out(a_dout), .data_oe_n(a_oe_n));
    dcff_port_master #(.WR_LEVEL(1'b0)) pb (
        .clk_sys(clk_sys), .port_clock(b_clk), .select_n(b_sel_n), .direction(b_dir), .enable(b_en),
        .mail_select(b_mail), .data_in(b_din), .data_out(b_dout), .data_oe_n(b_oe_n));
    task automatic check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic a_op(input int k, input logic mail, input logic [DATA_W-1:0] d);
        pa.op(1'b0, k == WR, k != IDLE, mail, d, q, oe);
    endtask : a_op
    task automatic b_op(input int k, input logic mail, input logic [DATA_W-1:0] d);
        pb.op(1'b0, k == WR, k != IDLE, mail, d, q, oe);
    endtask : b_op
    function automatic logic [DATA_W-1:0] word(input int n);
        return 36'h300000000 + 36'(n);
    endfunction : word
    task automatic do_reset(input logic ft);
        @(negedge clk_sys);
        rstn <= 1'b0;
        fall_through_mode <= ft;
        repeat (4) @(negedge clk_sys);
        rstn <= 1'b1;
        repeat (6) @(negedge clk_sys);
        a_op(IDLE, 1'b0, '0);
        a_op(IDLE, 1'b0, '0);
        b_op(IDLE, 1'b0, '0);
        b_op(IDLE, 1'b0, '0);
        check("a full", a_for, 1'b1);
        check("b full", b_for, 1'b1);
    endtask : do_reset
    task automatic final_report;
        if (miscompares == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            miscompares++;
            final_report();
        end
    end
    initial
    begin
        rstn = 1'b0;
        fall_through_mode = 1'b0;
        do_reset(1'b0);
        a_op(WR, 1'b0, word(0));
        b_op(IDLE, 1'b0, '0);
        check("b empty edge1", b_eor, 1'b0);
        b_op(IDLE, 1'b0, '0);
        check("b empty edge2", b_eor, 1'b1);
        b_op(RD, 1'b0, '0);
        check("b word", q, word(0));
        b_op(RD, 1'b0, '0);
        check("b empty read", q, word(0));
        check("b empty", b_eor, 1'b0);
        // one write past full must vanish
        for (i = 1; i <= DEPTH_T + 1; i++)
        begin
            a_op(WR, 1'b0, word(i));
            a_op(IDLE, 1'b0, '0);
            check("a almost full", a_afn, i < DEPTH_T - Y1);
            check("a full", a_for, i < DEPTH_T);
        end
        b_op(IDLE, 1'b0, '0);
        b_op(IDLE, 1'b0, '0);
        check("b almost empty", b_aen, 1'b1);
        for (i = 1; i <= DEPTH_T; i++)
        begin
            b_op(RD, 1'b0, '0);
            check("b drain", q, word(i));
            check("b almost empty", b_aen, DEPTH_T - i > X1);
            if (i == 1)
            begin
                a_op(IDLE, 1'b0, '0);
                check("a full edge1", a_for, 1'b0);
                a_op(IDLE, 1'b0, '0);
                check("a full edge2", a_for, 1'b1);
            end
            b_op(IDLE, 1'b0, '0);
        end
        b_op(RD, 1'b0, '0);
        check("b drained", q, word(DEPTH_T));
        check("b empty", b_eor, 1'b0);
        a_op(WR, 1'b1, 36'h0c0ffee01);
        check("mail one flag", mb1_n, 1'b0);
        a_op(WR, 1'b1, 36'h011111111);
        b_op(RD, 1'b1, '0);
        check("mail one data", q, 36'h0c0ffee01);
        check("mail one flag", mb1_n, 1'b1);
        b_op(WR, 1'b1, 36'h022222222);
        check("mail two flag", mb2_n, 1'b0);
        a_op(RD, 1'b1, '0);
        check("mail two data", q, 36'h022222222);
        check("mail two flag", mb2_n, 1'b1);
        pb.op(1'b1, 1'b0, 1'b0, 1'b0, '0, q, oe);
        check("b oe deselected", oe, 1'b1);
        b_op(IDLE, 1'b0, '0);
        check("b oe reading", oe, 1'b0);
        pa.op(1'b1, 1'b0, 1'b0, 1'b0, '0, q, oe);
        check("a oe deselected", oe, 1'b1);
        pa.op(1'b0, 1'b1, 1'b0, 1'b0, '0, q, oe);
        check("a oe writing", oe, 1'b1);
        do_reset(1'b1);
        for (i = 0; i <= X2 + 1; i++)
            b_op(WR, 1'b0, word(20 + i));
        a_op(IDLE, 1'b0, '0);
        check("a ready edge1", a_eor, 1'b0);
        a_op(IDLE, 1'b0, '0);
        check("a ready edge2", a_eor, 1'b0);
        a_op(IDLE, 1'b0, '0);
        check("a ready edge3", a_eor, 1'b1);
        check("a fall through", q, word(20));
        check("a almost empty", a_aen, 1'b1);
        for (i = 1; i <= X2 + 1; i++)
        begin
            a_op(RD, 1'b0, '0);
            check("a read", q, word(20 + i));
            check("a almost empty", a_aen, X2 + 1 - i > X2);
        end
        a_op(RD, 1'b0, '0);
        check("a ready", a_eor, 1'b0);
        check("a held word", q, word(21 + X2));
        // no port a edges here, so every word stays in memory and counts
        for (i = 1; i <= DEPTH_T - Y2; i++)
        begin
            b_op(WR, 1'b0, word(40 + i));
            check("b almost full", b_afn, i < DEPTH_T - Y2);
            check("b ready", b_for, 1'b1);
        end
        final_report();
    end
endmodule : tb
`default_nettype wire
